//--- hdl/pse_event_logic.sv
`include "pse_params.svh"
module pse_event_logic #(
	parameter int unsigned CYC_PER_SEC = `PSE_SEC_S * `PSE_REF_HZ, // Cycles per second
	parameter int          P_TCOMP     = 1,                         // Pa per whole degree
	parameter logic [7:0]  P_TRIM_NVM  = 8'h00,                     // Factory pressure trim
	parameter logic [7:0]  T_TRIM_NVM  = 8'h00                      // Factory temp trim
) (
	input  wire logic                   ref_clk,          // System clock
	input  wire logic                   resetn,           // Sync reset, low
	input  wire logic                   psel,             // APB select
	input  wire logic                   penable,          // APB enable
	input  wire logic                   pwrite,           // APB direction
	input  wire logic [`PSE_AW-1:0]     paddr,            // APB byte address
	input  wire logic [31:0]            pwdata,           // APB write data
	output logic      [31:0]            prdata,           // APB read data
	output logic                        pready,           // APB ready
	output logic                        pslverr,          // APB error
	input  wire logic                   afe_clk,          // Front-end link clock
	input  wire logic                   afe_valid,        // Front-end result valid
	input  wire logic [19:0]            afe_press,        // Pressure, pascals
	input  wire logic [11:0]            afe_temp,         // Temperature, 1/16 degree
	output logic                        afe_enable,       // Analog path power
	output logic                        afe_start,        // Conversion request
	output logic                        event_pin_one_o,  // Pin one level
	output logic                        event_pin_one_oe, // Pin one drive enable
	output logic                        event_pin_two_o,  // Pin two level
	output logic                        event_pin_two_oe, // Pin two drive enable
	output pse_pkg::pse_state_t         acq_state         // Acquisition state
);
	import pse_pkg::*;

	localparam int DEPTH = `PSE_FIFO_DEPTH;

	logic [33:0]        s1_q;
	logic [33:0]        s2_q;
	logic               ck3_q;
	logic [3:0]         ctrl_q, ctrl_d;
	logic [1:0]         sts_q, sts_d;
	logic [19:0]        p_out_q, p_out_d, p_dlt_q, p_dlt_d;
	logic [19:0]        p_min_q, p_min_d, p_max_q, p_max_d;
	logic [11:0]        t_out_q, t_out_d, t_dlt_q, t_dlt_d;
	logic [11:0]        t_min_q, t_min_d, t_max_q, t_max_d;
	logic               have_q, have_d, mm_q, mm_d;
	logic [8:0]         f_cfg_q, f_cfg_d;
	logic [15:0]        bar_q, bar_d, pressure_target_value_q, pressure_target_value_d, pressure_window_value_q, pressure_window_value_d;
	logic [7:0]         temperature_target_value_q, temperature_target_value_d, temperature_window_value_q, temperature_window_value_d;
	logic [7:0]         int_en_q, int_en_d, int_rt_q, int_rt_d, src_q, src_d;
	logic [3:0]         pin_cfg_q, pin_cfg_d;
	logic [7:0]         trim_p_q, trim_p_d, trim_t_q, trim_t_d;
	logic [15:0]        period_q, period_d, sec_q, sec_d;
	logic [4:0]         f_wr_q, f_wr_d, f_rd_q, f_rd_d;
	logic [5:0]         f_cnt_q, f_cnt_d;
	logic               f_ovf_q, f_ovf_d;
	pse_state_t         st_q, st_d;
	logic [31:0]        cyc_q, cyc_d;
	logic               start_q, start_d, en_q, en_d;
	logic               p1o_q, p1o_d, p1e_q, p1e_d, p2o_q, p2o_d, p2e_q, p2e_d;
	logic               rdy_q, rdy_d, err_q, err_d;
	logic [31:0]        rdat_q, rdat_d;
	logic [31:0]        fifo_mem [DEPTH];

	logic               alt, raw, cap, acc, wr, rd, push, pop, wmk;
	logic [19:0]        p_c, alt_s;
	logic signed [11:0] t_c;
	logic signed [23:0] p_sum;
	logic signed [20:0] pd;
	logic signed [31:0] alt_prod;
	logic signed [21:0] vn, vp, dv, pt_l, pw_l, tn, tp, dt, tt_l, tw_l, tc_l;
	logic [7:0]         set, clr;
	logic               lvl1, lvl2, act1, act2;
	logic [15:0]        per;
	pse_fifo_mode_t     f_mode;

	function automatic logic reach(input logic signed [21:0] a, b, l);
		return (a < l && b >= l) || (a > l && b <= l);
	endfunction

	function automatic logic inwin(input logic signed [21:0] v, t, w);
		return (w != 22'h000000) && (v >= t - w) && (v <= t + w);
	endfunction

	function automatic logic signed [21:0] absv(input logic signed [21:0] x);
		return (x < 22'sh000000) ? -x : x;
	endfunction

	function automatic logic signed [21:0] ext_p(input logic [19:0] x, input logic a);
		return a ? 22'($signed(x)) : 22'({2'b00, x});
	endfunction

	// Link clock is just sampled; edges found after two flops
	always_ff @(posedge ref_clk)
	begin
		s1_q  <= {afe_clk, afe_valid, afe_press, afe_temp};
		s2_q  <= s1_q;
		ck3_q <= s2_q[33];
	end

	assign alt    = ctrl_q[`PSE_CTRL_ALT];
	assign raw    = ctrl_q[`PSE_CTRL_RAW];
	assign f_mode = pse_fifo_mode_t'(f_cfg_q[7:6]);
	assign cap    = (st_q == PSE_CONV) && s2_q[33] && !ck3_q && s2_q[32];
	assign acc    = psel && penable && !rdy_q;
	assign wr     = psel && penable && rdy_q && pwrite;
	assign rd     = psel && penable && rdy_q && !pwrite;

	// Sample conditioning
	always_comb
	begin
		t_c      = raw ? $signed(s2_q[11:0])
		               : $signed(s2_q[11:0]) + 12'($signed(trim_t_q));
		p_sum    = 24'({4'h0, s2_q[31:12]}) + 24'($signed(trim_p_q))
		         + 24'(32'(t_c >>> 4) * P_TCOMP);
		p_c      = raw ? s2_q[31:12] : p_sum[19:0];
		pd       = $signed({4'h0, bar_q, 1'b0}) - $signed({1'b0, p_c});
		// Linear standard-atmosphere slope near sea level, Q16.4 result
		alt_prod = 32'(pd) * $signed(`PSE_ALT_MUL);
		alt_s    = 20'(alt_prod >>> `PSE_ALT_SH);
		vn       = (alt && !raw) ? 22'($signed(alt_s)) : 22'({2'b00, p_c});
		vp       = ext_p(p_out_q, alt);
		dv       = vn - vp;
		tn       = 22'(t_c);
		tp       = 22'($signed(t_out_q));
		dt       = tn - tp;
		pt_l     = alt ? 22'($signed({pressure_target_value_q, 4'h0})) : 22'({5'h00, pressure_target_value_q, 1'b0});
		pw_l     = alt ? 22'({2'b00, pressure_window_value_q, 4'h0}) : 22'({5'h00, pressure_window_value_q, 1'b0});
		tt_l     = 22'($signed({temperature_target_value_q, 4'h0}));
		tw_l     = 22'({10'h000, temperature_window_value_q, 4'h0});
		tc_l     = 22'({2'b00, pressure_window_value_q, 4'h0});
	end

	// Registers, sequencer, FIFO, flags and pins
	always_comb
	begin
		ctrl_d    = ctrl_q;
		sts_d     = sts_q;
		p_out_d   = p_out_q;
		p_dlt_d   = p_dlt_q;
		p_min_d   = p_min_q;
		p_max_d   = p_max_q;
		t_out_d   = t_out_q;
		t_dlt_d   = t_dlt_q;
		t_min_d   = t_min_q;
		t_max_d   = t_max_q;
		have_d    = have_q;
		mm_d      = mm_q;
		f_cfg_d   = f_cfg_q;
		bar_d     = bar_q;
		pressure_target_value_d   = pressure_target_value_q;
		pressure_window_value_d   = pressure_window_value_q;
		temperature_target_value_d   = temperature_target_value_q;
		temperature_window_value_d   = temperature_window_value_q;
		int_en_d  = int_en_q;
		int_rt_d  = int_rt_q;
		pin_cfg_d = pin_cfg_q;
		trim_p_d  = trim_p_q;
		trim_t_d  = trim_t_q;
		period_d  = period_q;
		f_wr_d    = f_wr_q;
		f_rd_d    = f_rd_q;
		f_cnt_d   = f_cnt_q;
		f_ovf_d   = f_ovf_q;
		st_d      = st_q;
		cyc_d     = cyc_q;
		sec_d     = sec_q;
		set       = 8'h00;
		clr       = 8'h00;
		rdy_d     = acc;
		err_d     = 1'b0;
		rdat_d    = 32'h0000_0000;
		push      = 1'b0;
		pop       = 1'b0;
		wmk       = 1'b0;
		per       = (period_q == 16'h0000) ? 16'h0001
		          : (period_q > `PSE_MAX_INT_S) ? `PSE_MAX_INT_S : period_q;

		if (acc)
		begin
			unique case (paddr)
				`PSE_A_CTRL:    rdat_d = {28'h0, ctrl_q};
				`PSE_A_STATUS:  rdat_d = {30'h0, sts_q};
				`PSE_A_P_OUT:   rdat_d = {12'h000, p_out_q};
				`PSE_A_T_OUT:   rdat_d = {16'h0000, t_out_q, 4'h0};
				`PSE_A_P_DLT:   rdat_d = {12'h000, p_dlt_q};
				`PSE_A_T_DLT:   rdat_d = {16'h0000, t_dlt_q, 4'h0};
				`PSE_A_P_MIN:   rdat_d = {12'h000, p_min_q};
				`PSE_A_P_MAX:   rdat_d = {12'h000, p_max_q};
				`PSE_A_T_MM:    rdat_d = {t_max_q, 4'h0, t_min_q, 4'h0};
				`PSE_A_F_CFG:   rdat_d = {23'h0, f_cfg_q};
				`PSE_A_F_DATA:  rdat_d = (f_cnt_q != 6'h00) ? fifo_mem[f_rd_q] : 32'h0000_0000;
				`PSE_A_F_STAT:  rdat_d = {24'h0, f_ovf_q, f_cnt_q >= f_cfg_q[5:0]
				                          && f_cfg_q[5:0] != 6'h00, f_cnt_q};
				`PSE_A_BAR:     rdat_d = {16'h0000, bar_q};
				`PSE_A_PRESSURE_TARGET_VALUE:   rdat_d = {16'h0000, pressure_target_value_q};
				`PSE_A_TEMPERATURE_TARGET_VALUE:   rdat_d = {24'h0, temperature_target_value_q};
				`PSE_A_PRESSURE_WINDOW_VALUE:   rdat_d = {16'h0000, pressure_window_value_q};
				`PSE_A_TEMPERATURE_WINDOW_VALUE:   rdat_d = {24'h0, temperature_window_value_q};
				`PSE_A_INT_EN:  rdat_d = {24'h0, int_en_q};
				`PSE_A_INT_RT:  rdat_d = {24'h0, int_rt_q};
				`PSE_A_PIN_CFG: rdat_d = {28'h0, pin_cfg_q};
				`PSE_A_INT_SRC: rdat_d = {24'h0, src_q};
				`PSE_A_TRIM:    rdat_d = {16'h0000, trim_t_q, trim_p_q};
				`PSE_A_PERIOD:  rdat_d = {16'h0000, period_q};
				`PSE_A_SYSMOD:  rdat_d = {30'h0, st_q};
				default:        err_d  = 1'b1;
			endcase
		end

		if (wr)
		begin
			unique case (paddr)
				`PSE_A_CTRL:    ctrl_d    = pwdata[3:0];
				`PSE_A_P_MIN:   mm_d      = 1'b0;
				`PSE_A_F_CFG:   f_cfg_d   = pwdata[8:0];
				`PSE_A_BAR:     bar_d     = pwdata[15:0];
				`PSE_A_PRESSURE_TARGET_VALUE:   pressure_target_value_d   = pwdata[15:0];
				`PSE_A_TEMPERATURE_TARGET_VALUE:   temperature_target_value_d   = pwdata[7:0];
				`PSE_A_PRESSURE_WINDOW_VALUE:   pressure_window_value_d   = pwdata[15:0];
				`PSE_A_TEMPERATURE_WINDOW_VALUE:   temperature_window_value_d   = pwdata[7:0];
				`PSE_A_INT_EN:  int_en_d  = pwdata[7:0];
				`PSE_A_INT_RT:  int_rt_d  = pwdata[7:0];
				`PSE_A_PIN_CFG: pin_cfg_d = pwdata[3:0];
				`PSE_A_INT_SRC: clr       = pwdata[7:0];
				`PSE_A_TRIM:
				begin
					trim_p_d = pwdata[7:0];
					trim_t_d = pwdata[15:8];
				end
				`PSE_A_PERIOD:  period_d  = pwdata[15:0];
				default:        ;
			endcase
		end

		if (rd && paddr == `PSE_A_STATUS)
			sts_d = 2'b00;
		if (rd && paddr == `PSE_A_F_STAT)
			f_ovf_d = 1'b0;
		if (rd && paddr == `PSE_A_F_DATA && f_cnt_q != 6'h00)
			pop = 1'b1;

		// Acquisition sequencer
		unique case (st_q)
			PSE_IDLE:
				if (ctrl_q[`PSE_CTRL_SBY] || ctrl_q[`PSE_CTRL_OST])
					st_d = PSE_CONV;
			PSE_CONV:
				if (cap)
				begin
					if (ctrl_q[`PSE_CTRL_SBY])
					begin
						st_d  = PSE_WAIT;
						cyc_d = 32'h0000_0000;
						sec_d = per;
					end
					else
					begin
						st_d                  = PSE_IDLE;
						ctrl_d[`PSE_CTRL_OST] = 1'b0;
					end
				end
			PSE_WAIT:
				if (!ctrl_q[`PSE_CTRL_SBY])
					st_d = PSE_IDLE;
				else if (cyc_q >= 32'(CYC_PER_SEC - 1))
				begin
					cyc_d = 32'h0000_0000;
					sec_d = sec_q - 16'h0001;
					if (sec_q <= 16'h0001)
						st_d = PSE_CONV;
				end
				else
					cyc_d = cyc_q + 32'h0000_0001;
			default:
				st_d = PSE_IDLE;
		endcase

		if (cap)
		begin
			sts_d   = {sts_q[0], 1'b1};
			set[`PSE_SRC_DRDY] = 1'b1;
			p_out_d = vn[19:0];
			t_out_d = t_c;
			have_d  = 1'b1;
			if (!raw)
			begin
				p_dlt_d = have_q ? dv[19:0] : 20'h00000;
				t_dlt_d = have_q ? dt[11:0] : 12'h000;
				if (!mm_q || vn < ext_p(p_min_q, alt))
					p_min_d = vn[19:0];
				if (!mm_q || vn > ext_p(p_max_q, alt))
					p_max_d = vn[19:0];
				if (!mm_q || tn < 22'($signed(t_min_q)))
					t_min_d = t_c;
				if (!mm_q || tn > 22'($signed(t_max_q)))
					t_max_d = t_c;
				mm_d = 1'b1;
				set[`PSE_PRESSURE_CHANGE_FLAG] = have_q && absv(dv) > pw_l;
				set[`PSE_TEMPERATURE_CHANGE_FLAG] = have_q && absv(dt) > tc_l;
				set[`PSE_PRESSURE_THRESHOLD_FLAG]  = have_q && (reach(vp, vn, pt_l) || (pw_l != 22'h000000 &&
				                     (reach(vp, vn, pt_l - pw_l) ||
				                      reach(vp, vn, pt_l + pw_l))));
				set[`PSE_TEMPERATURE_THRESHOLD_FLAG]  = have_q && (reach(tp, tn, tt_l) || (tw_l != 22'h000000 &&
				                     (reach(tp, tn, tt_l - tw_l) ||
				                      reach(tp, tn, tt_l + tw_l))));
				set[`PSE_PRESSURE_IN_WINDOW_FLAG]   = inwin(vn, pt_l, pw_l);
				set[`PSE_TEMPERATURE_IN_WINDOW_FLAG]   = inwin(tn, tt_l, tw_l);
				push = (f_mode != PSE_FIFO_OFF);
			end
		end

		// FIFO pointers; stop mode drops the newest when full
		if (push && f_cnt_q == 6'(DEPTH) && !pop)
		begin
			f_ovf_d = 1'b1;
			set[`PSE_SRC_FIFO] = 1'b1;
			if (f_mode == PSE_FIFO_WRAP)
			begin
				f_wr_d = f_wr_q + 5'h01;
				f_rd_d = f_rd_q + 5'h01;
			end
		end
		else
		begin
			if (push)
				f_wr_d = f_wr_q + 5'h01;
			if (pop)
				f_rd_d = f_rd_q + 5'h01;
			f_cnt_d = f_cnt_q + 6'(push) - 6'(pop);
			wmk = f_cfg_q[5:0] != 6'h00 && f_cnt_d >= f_cfg_q[5:0]
			      && f_cnt_q < f_cfg_q[5:0];
			if (wmk || (push && f_cfg_q[8] && |src_q[`PSE_TEMPERATURE_IN_WINDOW_FLAG:`PSE_PRESSURE_THRESHOLD_FLAG]))
				set[`PSE_SRC_FIFO] = 1'b1;
		end

		// Set wins over a clear in the same cycle
		src_d = (src_q & ~clr) | set;

		lvl1 = |(src_q & int_en_q & int_rt_q);
		lvl2 = |(src_q & int_en_q & ~int_rt_q);
		act1 = pin_cfg_q[0] ? lvl1 : !lvl1;
		act2 = pin_cfg_q[2] ? lvl2 : !lvl2;
		// Open drain can only pull low, so it drives when the level is low
		p1o_d = pin_cfg_q[1] ? 1'b0 : act1;
		p1e_d = pin_cfg_q[1] ? !act1 : 1'b1;
		p2o_d = pin_cfg_q[3] ? 1'b0 : act2;
		p2e_d = pin_cfg_q[3] ? !act2 : 1'b1;
		start_d = (st_d == PSE_CONV);
		en_d    = ctrl_d[`PSE_CTRL_SBY] || (st_d != PSE_IDLE);
	end

	always_ff @(posedge ref_clk)
	begin
		if (push && !(f_cnt_q == 6'(DEPTH) && !pop && f_mode == PSE_FIFO_STOP))
			fifo_mem[f_wr_q] <= {t_c, vn[19:0]};
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			ctrl_q    <= 4'h0;
			sts_q     <= 2'h0;
			p_out_q   <= 20'h00000;
			p_dlt_q   <= 20'h00000;
			p_min_q   <= 20'h00000;
			p_max_q   <= 20'h00000;
			t_out_q   <= 12'h000;
			t_dlt_q   <= 12'h000;
			t_min_q   <= 12'h000;
			t_max_q   <= 12'h000;
			have_q    <= 1'b0;
			mm_q      <= 1'b0;
			f_cfg_q   <= 9'h000;
			bar_q     <= `PSE_BAR_RST;
			pressure_target_value_q   <= 16'h0000;
			pressure_window_value_q   <= 16'h0000;
			temperature_target_value_q   <= 8'h00;
			temperature_window_value_q   <= 8'h00;
			int_en_q  <= 8'h00;
			int_rt_q  <= 8'h00;
			pin_cfg_q <= 4'h0;
			src_q     <= 8'h00;
			trim_p_q  <= P_TRIM_NVM;
			trim_t_q  <= T_TRIM_NVM;
			period_q  <= 16'h0001;
			f_wr_q    <= 5'h00;
			f_rd_q    <= 5'h00;
			f_cnt_q   <= 6'h00;
			f_ovf_q   <= 1'b0;
			st_q      <= PSE_IDLE;
			cyc_q     <= 32'h0000_0000;
			sec_q     <= 16'h0000;
			start_q   <= 1'b0;
			en_q      <= 1'b0;
			p1o_q     <= 1'b1;
			p1e_q     <= 1'b1;
			p2o_q     <= 1'b1;
			p2e_q     <= 1'b1;
			rdy_q     <= 1'b0;
			err_q     <= 1'b0;
			rdat_q    <= 32'h0000_0000;
		end
		else
		begin
			ctrl_q    <= ctrl_d;
			sts_q     <= sts_d;
			p_out_q   <= p_out_d;
			p_dlt_q   <= p_dlt_d;
			p_min_q   <= p_min_d;
			p_max_q   <= p_max_d;
			t_out_q   <= t_out_d;
			t_dlt_q   <= t_dlt_d;
			t_min_q   <= t_min_d;
			t_max_q   <= t_max_d;
			have_q    <= have_d;
			mm_q      <= mm_d;
			f_cfg_q   <= f_cfg_d;
			bar_q     <= bar_d;
			pressure_target_value_q   <= pressure_target_value_d;
			pressure_window_value_q   <= pressure_window_value_d;
			temperature_target_value_q   <= temperature_target_value_d;
			temperature_window_value_q   <= temperature_window_value_d;
			int_en_q  <= int_en_d;
			int_rt_q  <= int_rt_d;
			pin_cfg_q <= pin_cfg_d;
			src_q     <= src_d;
			trim_p_q  <= trim_p_d;
			trim_t_q  <= trim_t_d;
			period_q  <= period_d;
			f_wr_q    <= f_wr_d;
			f_rd_q    <= f_rd_d;
			f_cnt_q   <= f_cnt_d;
			f_ovf_q   <= f_ovf_d;
			st_q      <= st_d;
			cyc_q     <= cyc_d;
			sec_q     <= sec_d;
			start_q   <= start_d;
			en_q      <= en_d;
			p1o_q     <= p1o_d;
			p1e_q     <= p1e_d;
			p2o_q     <= p2o_d;
			p2e_q     <= p2e_d;
			rdy_q     <= rdy_d;
			err_q     <= err_d;
			rdat_q    <= rdat_d;
		end
	end

	assign prdata           = rdat_q;
	assign pready           = rdy_q;
	assign pslverr          = err_q;
	assign afe_enable       = en_q;
	assign afe_start        = start_q;
	assign event_pin_one_o  = p1o_q;
	assign event_pin_one_oe = p1e_q;
	assign event_pin_two_o  = p2o_q;
	assign event_pin_two_oe = p2e_q;
	assign acq_state        = st_q;
endmodule

//--- hdl/pse_params.svh
`ifndef PSE_PARAMS_SVH
`define PSE_PARAMS_SVH

`define PSE_AW         8
`define PSE_A_CTRL     8'h00
`define PSE_A_STATUS   8'h04
`define PSE_A_P_OUT    8'h08
`define PSE_A_T_OUT    8'h0C
`define PSE_A_P_DLT    8'h10
`define PSE_A_T_DLT    8'h14
`define PSE_A_P_MIN    8'h18
`define PSE_A_P_MAX    8'h1C
`define PSE_A_T_MM     8'h20
`define PSE_A_F_CFG    8'h24
`define PSE_A_F_DATA   8'h28
`define PSE_A_F_STAT   8'h2C
`define PSE_A_BAR      8'h30
`define PSE_A_PRESSURE_TARGET_VALUE    8'h34
`define PSE_A_TEMPERATURE_TARGET_VALUE    8'h38
`define PSE_A_PRESSURE_WINDOW_VALUE    8'h3C
`define PSE_A_TEMPERATURE_WINDOW_VALUE    8'h40
`define PSE_A_INT_EN   8'h44
`define PSE_A_INT_RT   8'h48
`define PSE_A_PIN_CFG  8'h4C
`define PSE_A_INT_SRC  8'h50
`define PSE_A_TRIM     8'h54
`define PSE_A_PERIOD   8'h58
`define PSE_A_SYSMOD   8'h5C

`define PSE_CTRL_SBY   0
`define PSE_CTRL_OST   1
`define PSE_CTRL_ALT   2
`define PSE_CTRL_RAW   3

`define PSE_PRESSURE_CHANGE_FLAG   0
`define PSE_TEMPERATURE_CHANGE_FLAG   1
`define PSE_PRESSURE_THRESHOLD_FLAG    2
`define PSE_TEMPERATURE_THRESHOLD_FLAG    3
`define PSE_PRESSURE_IN_WINDOW_FLAG     4
`define PSE_TEMPERATURE_IN_WINDOW_FLAG     5
`define PSE_SRC_FIFO   6
`define PSE_SRC_DRDY   7

`define PSE_BAR_RST    16'hC5E7
`define PSE_FIFO_DEPTH 32
`define PSE_SEC_S      1
`define PSE_REF_HZ     100000000
`define PSE_MAX_INT_S  16'h7E90
`define PSE_ALT_MUL    32'h0000_0565
`define PSE_ALT_SH     10

`endif

//--- hdl/pse_pkg.sv
package pse_pkg;
	typedef enum logic [1:0]
	{
		PSE_IDLE = 2'b00,
		PSE_CONV = 2'b01,
		PSE_WAIT = 2'b10
	} pse_state_t;

	typedef enum logic [1:0]
	{
		PSE_FIFO_OFF  = 2'b00,
		PSE_FIFO_WRAP = 2'b01,
		PSE_FIFO_STOP = 2'b10
	} pse_fifo_mode_t;
endpackage

//--- sim/pse_event_logic_sva.sv
module pse_event_logic_sva (
	input logic                ref_clk,          // Clock
	input logic                resetn,           // Sync reset, low
	input logic                psel,             // APB select
	input logic                penable,          // APB enable
	input logic [31:0]         prdata,           // APB read data
	input logic                pready,           // APB ready
	input logic                pslverr,          // APB error
	input logic                afe_enable,       // Analog power
	input logic                afe_start,        // Conversion request
	input logic                event_pin_one_o,  // Pin one level
	input logic                event_pin_one_oe, // Pin one enable
	input logic                event_pin_two_o,  // Pin two level
	input logic                event_pin_two_oe, // Pin two enable
	input pse_pkg::pse_state_t acq_state         // Acquisition state
);
	import pse_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	chk_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("ready not one cycle after access");
	chk_ready_single: assert property (pready |-> psel && penable ##1 !pready)
		else $error("ready outside access or too long");
	chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error without ready or with data");
	chk_start_conv: assert property (afe_start |-> acq_state == PSE_CONV)
		else $error("start outside conversion");
	chk_start_power: assert property (afe_start |-> afe_enable)
		else $error("start with analog path off");
	chk_conv_leave: assert property ($fell(afe_start) |-> acq_state != PSE_CONV)
		else $error("state stays in conversion after capture");
	chk_pin_one_od: assert property (!event_pin_one_oe |-> !event_pin_one_o)
		else $error("pin one released but high");
	chk_pin_two_od: assert property (!event_pin_two_oe |-> !event_pin_two_o)
		else $error("pin two released but high");
	chk_reset_idle: assert property (disable iff (1'b0) !resetn |=> !pready && !afe_start
		&& acq_state == PSE_IDLE && event_pin_one_o && event_pin_one_oe)
		else $error("outputs not idle after reset");
endmodule

bind pse_event_logic pse_event_logic_sva u_pse_event_logic_sva (.ref_clk, .resetn, .psel,
	.penable, .prdata, .pready, .pslverr, .afe_enable, .afe_start, .event_pin_one_o,
	.event_pin_one_oe, .event_pin_two_o, .event_pin_two_oe, .acq_state);

//--- sim/pse_afe_model.sv
module pse_afe_model (
	input  logic        afe_start,  // Conversion request
	input  logic [19:0] next_press, // Pressure to return
	input  logic [11:0] next_temp,  // Temperature to return
	output logic        afe_clk,    // Link clock, still between frames
	output logic        afe_valid,  // Result valid
	output logic [19:0] afe_press,  // Pressure
	output logic [11:0] afe_temp    // Temperature
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		afe_clk = 1'b0;
		afe_valid = 1'b0;
		afe_press = 20'h00000;
		afe_temp = 12'h000;
		forever
		begin
			wait (afe_start === 1'b1);
			#100;
			afe_press = next_press;
			afe_temp = next_temp;
			afe_valid = 1'b1;
			while (afe_start === 1'b1)
			begin
				#40 afe_clk = 1'b1;
				#40 afe_clk = 1'b0;
			end
			// Stale data must not look valid
			afe_valid = 1'b0;
			afe_press = ~afe_press;
			afe_temp = ~afe_temp;
		end
	end
endmodule

//--- sim/testbench.sv
`include "pse_params.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pse_pkg::*;
	typedef struct packed {logic [7:0] a; logic w; logic [31:0] d;
		logic [31:0] e; logic x;} pse_row_t;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, afe_clk, afe_valid, afe_enable, afe_start;
	logic p1o, p1oe, p2o, p2oe;
	logic [19:0] afe_press, nx_press = 20'h0;
	logic [11:0] afe_temp, nx_temp = 12'h0;
	pse_state_t acq_state;
	int num_errors = 0;
	int n_checks = 0;
	pse_row_t rows [16] = '{
		'{`PSE_A_CTRL, 1'b0, 32'h0, 32'h0, 1'b0}, '{`PSE_A_BAR, 1'b0, 32'h0, 32'hC5E7, 1'b0},
		'{`PSE_A_STATUS, 1'b0, 32'h0, 32'h0, 1'b0}, '{`PSE_A_SYSMOD, 1'b0, 32'h0, 32'h0, 1'b0},
		'{`PSE_A_P_OUT, 1'b1, 32'hFFFFF, 32'h0, 1'b0}, '{`PSE_A_P_OUT, 1'b0, 32'h0, 32'h0, 1'b0},
		'{`PSE_A_INT_SRC, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h60, 1'b0, 32'h0, 32'h0, 1'b1},
		'{`PSE_A_PRESSURE_TARGET_VALUE, 1'b1, 32'h1234, 32'h0, 1'b0}, '{`PSE_A_PRESSURE_TARGET_VALUE, 1'b0, 32'h0, 32'h1234, 1'b0},
		'{`PSE_A_PRESSURE_WINDOW_VALUE, 1'b1, 32'hA, 32'h0, 1'b0}, '{`PSE_A_PIN_CFG, 1'b1, 32'h9, 32'h0, 1'b0},
		'{`PSE_A_PIN_CFG, 1'b0, 32'h0, 32'h9, 1'b0}, '{`PSE_A_INT_EN, 1'b1, 32'h81, 32'h0, 1'b0},
		'{`PSE_A_INT_RT, 1'b1, 32'h80, 32'h0, 1'b0}, '{`PSE_A_TEMPERATURE_WINDOW_VALUE, 1'b0, 32'h0, 32'h0, 1'b0}};

	always #5 ref_clk = ~ref_clk;

	pse_event_logic #(.CYC_PER_SEC(20)) u_pse_event_logic (.ref_clk, .resetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .afe_clk, .afe_valid, .afe_press,
		.afe_temp, .afe_enable, .afe_start, .event_pin_one_o(p1o), .event_pin_one_oe(p1oe),
		.event_pin_two_o(p2o), .event_pin_two_oe(p2oe), .acq_state);
	pse_afe_model u_pse_afe_model (.afe_start, .next_press(nx_press), .next_temp(nx_temp),
		.afe_clk, .afe_valid, .afe_press, .afe_temp);

	task end_of_test;
		$display("Errors %0d, checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task hang;
		num_errors++;
		$display("[FAIL] %0t wait timed out", $time);
		end_of_test();
	endtask
	task chk32(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task chk1(input logic g, input logic e);
		n_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %0t bit %b expected %b", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge ref_clk);
			i++;
		end
		while (pready !== 1'b1 && i < 50);
		if (i >= 50)
			hang();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk32(rd, e);
	endtask
	task wait_st(input pse_state_t s);
		for (int i = 0; i < 300 && acq_state !== s; i++)
			@(posedge ref_clk);
		if (acq_state !== s)
			hang();
	endtask
	// One conversion; temperature in 1/16 degree, one Pa added per degree
	task sample(input logic [19:0] p, input logic [11:0] t, input logic [31:0] c);
		nx_press = p;
		nx_temp = t;
		apb(1'b1, `PSE_A_CTRL, c);
		wait_st(PSE_CONV);
		wait_st(PSE_IDLE);
	endtask

	initial
	begin
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		foreach (rows[k])
		begin
			apb(rows[k].w, rows[k].a, rows[k].d);
			chk1(er, rows[k].x);
			if (!rows[k].w)
				chk32(rd, rows[k].e);
		end
		chk1(p1o, 1'b0);
		chk1(p2oe, 1'b0);
		sample(20'h186A0, 12'h190, 32'h2);
		rdc(`PSE_A_P_OUT, 32'h186B9);
		rdc(`PSE_A_T_OUT, 32'h1900);
		rdc(`PSE_A_CTRL, 32'h0);
		rdc(`PSE_A_STATUS, 32'h1);
		apb(1'b1, `PSE_A_TRIM, 32'h5);
		sample(20'h18704, 12'h190, 32'h2);
		rdc(`PSE_A_P_OUT, 32'h18722);
		rdc(`PSE_A_P_DLT, 32'h69);
		rdc(`PSE_A_T_DLT, 32'h0);
		rdc(`PSE_A_P_MIN, 32'h186B9);
		rdc(`PSE_A_P_MAX, 32'h18722);
		rdc(`PSE_A_INT_SRC, 32'h81);
		chk1(p1o, 1'b1);
		chk1(p2oe, 1'b1);
		apb(1'b1, `PSE_A_INT_SRC, 32'hFF);
		repeat (3) @(posedge ref_clk);
		chk1(p1o, 1'b0);
		chk1(p2oe, 1'b0);
		chk1(p2o, 1'b0);
		apb(1'b1, `PSE_A_TEMPERATURE_TARGET_VALUE, 32'h1A);
		sample(20'h18704, 12'h1B0, 32'h2);
		rdc(`PSE_A_INT_SRC, 32'h88);
		apb(1'b1, `PSE_A_INT_SRC, 32'hFF);
		sample(20'h15F90, 12'h190, 32'hA);
		rdc(`PSE_A_INT_SRC, 32'h80);
		rdc(`PSE_A_CTRL, 32'h8);
		rdc(`PSE_A_P_MIN, 32'h186B9);
		rdc(`PSE_A_P_DLT, 32'h2);
		apb(1'b1, `PSE_A_PERIOD, 32'h1);
		apb(1'b1, `PSE_A_F_CFG, 32'h42);
		apb(1'b1, `PSE_A_CTRL, 32'h1);
		wait_st(PSE_WAIT);
		chk1(afe_enable, 1'b1);
		wait_st(PSE_CONV);
		wait_st(PSE_WAIT);
		rdc(`PSE_A_F_STAT, 32'h42);
		apb(1'b0, `PSE_A_INT_SRC, 32'h0);
		chk32(rd & 32'h40, 32'h40);
		rdc(`PSE_A_F_DATA, 32'h19015FAE);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk1(afe_enable, 1'b0);
		chk1(p1oe, 1'b1);
		resetn <= 1'b1;
		rdc(`PSE_A_CTRL, 32'h0);
		rdc(`PSE_A_BAR, 32'hC5E7);
		apb(1'b1, `PSE_A_PIN_CFG, 32'h2);
		sample(20'h187B5, 12'h190, 32'h6);
		rdc(`PSE_A_P_OUT, 32'h565);
		sample(20'h18FB5, 12'h190, 32'h6);
		rdc(`PSE_A_P_OUT, 32'hFFA9B);
		rdc(`PSE_A_P_DLT, 32'hFF536);
		rdc(`PSE_A_P_MIN, 32'hFFA9B);
		chk1(p1oe, 1'b0);
		chk1(p1o, 1'b0);
		end_of_test();
	end
endmodule
